//--- hw/eirq_top.sv
// External interrupt input block with its APB register slave.
// Operation
// - Polarity bits 7 and 3 of config; 0 active low, 1 active high.
// - Sensitivity bit per input; 1 edge sensitive, 0 level sensitive.
// - Pin select fields 6:4 and 2:0; code n picks port 0 pin n.
// - Logic only observes its pin, never drives or disturbs it.
// - Pending flags at timer control bits 1 and 3 drive core requests.
// - Edge mode: active transition sets flag; core vectoring clears it.
// - Level mode: flag equals active level of input, no latching.
// Assumes a core that pulses irq_ack for one cycle when it vectors.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module eirq_top
  import eirq_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port0_pin,
  input wire logic [1:0] irq_ack,
  output logic [1:0] irq_req
);

  eirq_cfg_t cfg_reg, cfg_next;
  logic [1:0] edge_reg, edge_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [2:0] quiet_reg, quiet_next;
  logic [2:0] chan_sel [EIRQ_NCH];
  logic [1:0] chan_pol;
  logic [1:0] pend;
  logic accept, hit_cfg, hit_ctl;
  logic [31:0] rd_mux;

  assign hit_cfg = (paddr == EIRQ_CFG_OFS);
  assign hit_ctl = (paddr == EIRQ_CTL_OFS);
  assign accept = psel & penable & pready_reg;

  always_comb begin
    rd_mux = 32'h0;
    if (hit_cfg) begin
      rd_mux[7:0] = cfg_reg;
    end
    if (hit_ctl) begin
      rd_mux[EIRQ_CTL_EDGE0_BIT] = edge_reg[0];
      rd_mux[EIRQ_CTL_EDGE1_BIT] = edge_reg[1];
      rd_mux[EIRQ_CTL_PEND0_BIT] = pend[0];
      rd_mux[EIRQ_CTL_PEND1_BIT] = pend[1];
    end
  end

  // Bus slave: one wait state, answer registered
  always_comb begin
    pready_next = psel & penable & ~pready_reg;
    pslverr_next = pready_next & ~(hit_cfg | hit_ctl);
    prdata_next = (pready_next & ~pwrite) ? rd_mux : 32'h0;
    cfg_next = cfg_reg;
    edge_next = edge_reg;
    if (accept & pwrite & hit_cfg) begin
      cfg_next = pwdata[7:0];
    end
    if (accept & pwrite & hit_ctl) begin
      edge_next[0] = pwdata[EIRQ_CTL_EDGE0_BIT];
      edge_next[1] = pwdata[EIRQ_CTL_EDGE1_BIT];
    end
    if (accept & pwrite & (hit_cfg | hit_ctl)) begin
      quiet_next = 3'h0;
    end else if (quiet_reg == EIRQ_QUIET_MAX) begin
      quiet_next = quiet_reg;
    end else begin
      quiet_next = quiet_reg + 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfg_reg <= EIRQ_CFG_RST;
      edge_reg <= EIRQ_EDGE_RST;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
      quiet_reg <= 3'h0;
    end else begin
      cfg_reg <= cfg_next;
      edge_reg <= edge_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
      quiet_reg <= quiet_next;
    end
  end

  assign chan_sel[0] = cfg_reg.irq_zero_pin_select;
  assign chan_sel[1] = cfg_reg.irq_one_pin_select;
  assign chan_pol = {cfg_reg.irq_one_polarity, cfg_reg.irq_zero_polarity};

  genvar c;
  generate
    for (c = 0; c < EIRQ_NCH; c++) begin : g_chan
      eirq_chan u_chan (
        .mclk(mclk),
        .resetn(resetn),
        .port0_pin(port0_pin),
        .pin_sel(chan_sel[c]),
        .pol(chan_pol[c]),
        .edge_mode(edge_reg[c]),
        .ack(irq_ack[c]),
        .pending(pend[c])
      );
    end
  endgenerate

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq_req = pend;

  // Checks
  logic [1:0] act;
  assign act[0] = port0_pin[chan_sel[0]] ~^ chan_pol[0];
  assign act[1] = port0_pin[chan_sel[1]] ~^ chan_pol[1];

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  a_reset_values: assert property (
    $rose(resetn) |-> (cfg_reg == EIRQ_CFG_RST && edge_reg == 2'h0 && irq_req == 2'h0))
    else $error("reset values wrong");

  a_reset_quiet: assert property (
    $rose(resetn) |=> (irq_req == 2'h0) ##1 (irq_req == 2'h0))
    else $error("request raised right after reset");

  a_cfg_write: assert property (
    accept && pwrite && hit_cfg |=> cfg_reg == $past(pwdata[7:0]))
    else $error("config write lost");

  a_ctl_write: assert property (
    accept && pwrite && hit_ctl |=> edge_reg == {$past(pwdata[2]), $past(pwdata[0])})
    else $error("sensitivity write lost");

  a_apb_wait: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer timing wrong");

  a_pend_readback: assert property (
    pready && !pslverr && hit_ctl && !pwrite |-> prdata[1] == $past(irq_req[0]) && prdata[3] == $past(irq_req[1]))
    else $error("pending readback wrong");

  a_level_zero: assert property (
    !edge_reg[0] && quiet_reg >= EIRQ_QUIET_MIN |-> irq_req[0] == $past(act[0], 3))
    else $error("level flag zero not following input");

  a_level_one: assert property (
    !edge_reg[1] && quiet_reg >= EIRQ_QUIET_MIN |-> irq_req[1] == $past(act[1], 3))
    else $error("level flag one not following input");

  a_edge_set: assert property (
    edge_reg[0] && quiet_reg >= EIRQ_QUIET_MIN && $past(act[0], 2) && !$past(act[0], 3) |=> irq_req[0])
    else $error("edge did not set pending");

  a_edge_clear: assert property (
    edge_reg[1] && quiet_reg >= EIRQ_QUIET_MIN && irq_ack[1] && !($past(act[1], 2) && !$past(act[1], 3))
    |=> !irq_req[1])
    else $error("acknowledge did not clear pending");

  // Edge mode on the other input
  a_edge_set_one: assert property (
    edge_reg[1] && quiet_reg >= EIRQ_QUIET_MIN && $past(act[1], 2) && !$past(act[1], 3) |=> irq_req[1])
    else $error("edge did not set pending one");

  a_edge_clear_zero: assert property (
    edge_reg[0] && quiet_reg >= EIRQ_QUIET_MIN && irq_ack[0] && !($past(act[0], 2) && !$past(act[0], 3))
    |=> !irq_req[0])
    else $error("acknowledge did not clear pending zero");

  a_edge_hold: assert property (
    edge_reg[0] && irq_req[0] && !irq_ack[0] |=> irq_req[0])
    else $error("pending flag lost without acknowledge");

  // Register and bus checks
  a_cfg_hold: assert property (
    !(accept && pwrite && hit_cfg) |=> $stable(cfg_reg))
    else $error("config changed without a write");

  a_ctl_hold: assert property (
    !(accept && pwrite && hit_ctl) |=> $stable(edge_reg))
    else $error("sensitivity changed without a write");

  a_bad_addr: assert property (
    pready |-> pslverr == !(hit_cfg || hit_ctl))
    else $error("unmapped access not refused");

  a_rd_idle_zero: assert property (
    !pready |-> prdata == 32'h0)
    else $error("read data not zero while idle");

  c_edge_ack: cover property (edge_reg[0] && irq_req[0] ##1 irq_ack[0] ##1 !irq_req[0]);
  c_level_req: cover property (!edge_reg[1] && !irq_req[1] ##1 irq_req[1]);
  c_bad_addr: cover property (pready && pslverr);
  c_edge_one_set: cover property (edge_reg[1] && !irq_req[1] ##1 irq_req[1]);
  c_cfg_write: cover property (accept && pwrite && hit_cfg);

endmodule // eirq_top
`default_nettype wire

//--- hw/eirq_pkg.sv
// Package for the external interrupt input block: register map, field layout,
// reset values and pipeline figures.
// Assumes a single 25 MHz system clock and a synchronous active-low reset.
package eirq_pkg;

  localparam int EIRQ_NCH = 2;
  localparam int EIRQ_ADDR_W = 12;

  // Register byte addresses
  localparam logic [11:0] EIRQ_CFG_OFS = 12'h0e4;
  localparam logic [11:0] EIRQ_CTL_OFS = 12'h0e8;

  // Pin, polarity and select fields, laid out as the configuration register
  typedef struct packed {
    logic irq_one_polarity;
    logic [2:0] irq_one_pin_select;
    logic irq_zero_polarity;
    logic [2:0] irq_zero_pin_select;
  } eirq_cfg_t;

  localparam logic [7:0] EIRQ_CFG_RST = 8'h01;
  localparam logic [1:0] EIRQ_EDGE_RST = 2'h0;
  // Synchroniser reset level: inactive under the reset polarity (active low)
  localparam logic EIRQ_PIN_IDLE = 1'b1;

  // Bit positions in the timer control register
  localparam int EIRQ_CTL_EDGE0_BIT = 0;
  localparam int EIRQ_CTL_PEND0_BIT = 1;
  localparam int EIRQ_CTL_EDGE1_BIT = 2;
  localparam int EIRQ_CTL_PEND1_BIT = 3;

  // Settle counter after a register write
  localparam logic [2:0] EIRQ_QUIET_MAX = 3'h7;
  localparam logic [2:0] EIRQ_QUIET_MIN = 3'h4;

endpackage

//--- hw/eirq_chan.sv
// One external interrupt input: pin select, two-flop synchroniser,
// polarity, edge or level detection and the pending flag.
// Assumes pins and acknowledge are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module eirq_chan
  import eirq_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] port0_pin,
  input wire logic [2:0] pin_sel,
  input wire logic pol,
  input wire logic edge_mode,
  input wire logic ack,
  output logic pending
);

  logic sync1_reg, sync1_next;
  logic sync2_reg, sync2_next;
  logic prev_reg, prev_next;
  logic pend_reg, pend_next;
  logic active, prev_active, edge_seen;

  always_comb begin
    sync1_next = port0_pin[pin_sel];
    sync2_next = sync1_reg;
    prev_next = sync2_reg;
    active = sync2_reg ~^ pol;
    prev_active = prev_reg ~^ pol;
    edge_seen = active & ~prev_active;
    if (edge_mode) begin
      // set on edge, ack clears, set wins
      pend_next = edge_seen | (pend_reg & ~ack);
    end else begin
      pend_next = active;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      // Idle level, so no false request after reset
      sync1_reg <= EIRQ_PIN_IDLE;
      sync2_reg <= EIRQ_PIN_IDLE;
      prev_reg <= EIRQ_PIN_IDLE;
      pend_reg <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg <= prev_next;
      pend_reg <= pend_next;
    end
  end

  assign pending = pend_reg;

endmodule // eirq_chan
`default_nettype wire

//--- testbench/eirq_src.sv
// Model of the external sources that drive the port 0 pins.
// Assumes sources switch in step with mclk, as the bench asks.
`timescale 1ns/1ps
`default_nettype none
module eirq_src (
  input wire logic mclk,
  input wire logic [7:0] want,
  output logic [7:0] port0_pin
);
  always_ff @(posedge mclk) begin
    port0_pin <= want;
  end
endmodule // eirq_src
`default_nettype wire

//--- testbench/eirq_top_tb.sv
// Self-checking bench for the external interrupt input block.
// Assumes the APB slave and source model above; one 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module eirq_top_tb;
  import eirq_pkg::*;
  logic mclk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] want, port0_pin;
  logic [1:0] irq_ack, irq_req;
  int errors, checked;
  eirq_top eirq_top_i (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port0_pin(port0_pin), .irq_ack(irq_ack), .irq_req(irq_req));
  eirq_src eirq_src_i (.mclk(mclk), .want(want), .port0_pin(port0_pin));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic test_done;
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Setup, access, wait for pready, then release
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    chk({31'h0, pready}, 32'h1);
    chk({31'h0, pslverr}, {31'h0, err});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pins(input logic [7:0] w, input logic [1:0] exp);
    want <= w;
    wt(5);
    chk({30'h0, irq_req}, {30'h0, exp});
  endtask
  task automatic ack(input logic [1:0] a, input logic [1:0] exp);
    irq_ack <= a;
    wt(1);
    irq_ack <= 2'b00;
    wt(2);
    chk({30'h0, irq_req}, {30'h0, exp});
  endtask
  initial begin
    wt(2000);
    errors++;
    $display("FAIL %0t timeout", $time);
    test_done;
  end
  initial begin
    errors = 0;
    checked = 0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    want = 8'hff;
    irq_ack = 2'b00;
    wt(16);
    resetn <= 1'b1;
    apb(1'b0, EIRQ_CFG_OFS, 32'h0, 1'b0);
    chk(rd, 32'h01);
    apb(1'b0, EIRQ_CTL_OFS, 32'h0, 1'b0);
    chk(rd, 32'h0);
    chk({30'h0, irq_req}, 32'h0);
    apb(1'b1, EIRQ_CFG_OFS, 32'hffff_ffff, 1'b0);
    apb(1'b0, EIRQ_CFG_OFS, 32'h0, 1'b0);
    chk(rd, 32'hff);
    // Unmapped place refused
    apb(1'b0, 12'h0f0, 32'h0, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h0f0, 32'hffff_ffff, 1'b1);
    apb(1'b0, EIRQ_CTL_OFS, 32'h0, 1'b0);
    chk(rd, 32'h0a);
    // Both inputs on pin n, opposite polarity, level mode
    for (int n = 0; n < 8; n++) begin
      apb(1'b1, EIRQ_CFG_OFS, {24'h0, 1'b1, n[2:0], 1'b0, n[2:0]}, 1'b0);
      pins(~(8'h01 << n), 2'b01);
      pins(8'h01 << n, 2'b10);
      apb(1'b0, EIRQ_CTL_OFS, 32'h0, 1'b0);
      chk(rd, 32'h08);
    end
    // Input zero on pin 2 active high, input one on pin 5 active low
    apb(1'b1, EIRQ_CFG_OFS, 32'h5a, 1'b0);
    pins(8'h20, 2'b00);
    apb(1'b1, EIRQ_CTL_OFS, 32'h05, 1'b0);
    wt(4);
    pins(8'h04, 2'b11);
    pins(8'h20, 2'b11);
    apb(1'b0, EIRQ_CTL_OFS, 32'h0, 1'b0);
    chk(rd, 32'h0f);
    ack(2'b01, 2'b10);
    ack(2'b10, 2'b00);
    // Second reset with both flags set
    pins(8'h04, 2'b11);
    resetn <= 1'b0;
    wt(4);
    chk({30'h0, irq_req}, 32'h0);
    resetn <= 1'b1;
    apb(1'b0, EIRQ_CFG_OFS, 32'h0, 1'b0);
    chk(rd, 32'h01);
    apb(1'b0, EIRQ_CTL_OFS, 32'h0, 1'b0);
    chk(rd, 32'h0a);
    test_done;
  end
endmodule // eirq_top_tb
`default_nettype wire
